// ===== design/prsl_consts.svh
// Constants for the pin routing select and lock block
`ifndef PRSL_CONSTS_SVH
`define PRSL_CONSTS_SVH
`define PRSL_KEY_FIRST 8'h55
`define PRSL_KEY_SECOND 8'haa
`define PRSL_LOCK_BIT 0
`define PRSL_SEL_W 8
`define PRSL_OUT_SEL_RST 8'h00
`define PRSL_IN_SEL_RST 8'h00
`define PRSL_LOCK_RST 1'b0
`define PRSL_PICK_W 64
`endif

// ===== design/prsl_pkg.sv
// Types and helpers shared by the pin routing select and lock block
package prsl_pkg;
  // Which selection register a write targets
  typedef enum logic [1:0] {PRSL_TGT_LOCK, PRSL_TGT_OUT, PRSL_TGT_IN} prsl_tgt_e;
  // Keyed unlock sequence progress
  typedef enum logic [1:0] {PRSL_SEQ_IDLE, PRSL_SEQ_KEY1, PRSL_SEQ_ARMED} prsl_seq_e;
  // One-shot lock budget since the last device reset
  typedef enum logic [1:0] {PRSL_OS_FRESH, PRSL_OS_CLEARED, PRSL_OS_SPENT} prsl_os_e;
  // Input buffer kind chosen for a pin
  typedef enum logic [1:0] {PRSL_BUF_TTL, PRSL_BUF_SCHMITT, PRSL_BUF_I2C} prsl_buf_e;
  // One software write
  typedef struct packed {
    logic en;
    prsl_tgt_e tgt;
    logic [7:0] idx;
    logic [7:0] data;
  } prsl_wr_s;
  // Per-pin output path result
  typedef struct packed {
    logic out;
    logic oe;
    prsl_buf_e buf_kind;
  } prsl_pin_s;

  // Bit pick with zero for any index past the vector
  function automatic logic prsl_pick(input logic [63:0] v, input logic [7:0] i);
    logic r;
    r = 1'b0;
    if (i < 8'h40) r = v[i[5:0]];
    return r;
  endfunction : prsl_pick
endpackage : prsl_pkg

// ===== design/prsl_pin_slice.sv
// One pin's output source mux, driver ownership and buffer choice
`timescale 1ns/1ps
`include "prsl_consts.svh"
module prsl_pin_slice import prsl_pkg::*; #(
  parameter int N_SRC = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [`PRSL_SEL_W-1:0] i_sel,
  input wire logic [N_SRC-1:0] i_src,
  input wire logic [N_SRC-1:0] i_src_oe,
  input wire logic [N_SRC-1:0] i_src_ovr,
  input wire logic i_dir_input,
  input wire logic i_thresh_st,
  input wire logic i_i2c_here,
  output prsl_pin_s o_pin
);
  prsl_pin_s pin_d;
  prsl_pin_s pin_q;
  logic ovr;

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  // Same source list on every pin; out-of-range codes drive low
  always_comb begin
    ovr = prsl_pick(`PRSL_PICK_W'(i_src_ovr), i_sel);
    pin_d.out = prsl_pick(`PRSL_PICK_W'(i_src), i_sel);
    // Direction owns the driver unless the source claims it
    if (ovr) begin
      pin_d.oe = prsl_pick(`PRSL_PICK_W'(i_src_oe), i_sel);
    end else begin
      pin_d.oe = ~i_dir_input;
    end
    // Dedicated pins only; elsewhere the threshold setting stands
    if (i_i2c_here) begin
      pin_d.buf_kind = PRSL_BUF_I2C;
    end else if (i_thresh_st) begin
      pin_d.buf_kind = PRSL_BUF_SCHMITT;
    end else begin
      pin_d.buf_kind = PRSL_BUF_TTL;
    end
  end

  // Registered so the pad sees glitch-free data
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign o_pin = pin_q;
endmodule : prsl_pin_slice

// ===== design/prsl_top.sv
// Pin routing fabric: per-pin output select, per-input select, keyed lock
// Function
// - Every pin has its own output source select, same source list for all.
// - Pin direction control owns the output driver for ordinary sources.
// - I2C and synchronous serial sources override direction with their own enable.
// - I2C buffers only on four dedicated pins; elsewhere threshold setting applies.
// - Lock bit set blocks every input and output selection change.
// - Lock bit change needs 0x55, then 0xAA, then the lock write.
// - One-shot option allows one clear then one set per device reset.
// - Sleep entry and exit leave all selections untouched.
// - Power-on reset restores defaults and unlock; other resets keep selections.
// - Only digital signals pass the fabric; analog stays on its pins.
// - Every peripheral input has its own select with identical pin choices.
`timescale 1ns/1ps
`include "prsl_consts.svh"
module prsl_top import prsl_pkg::*; #(
  parameter int N_PINS = 8,
  parameter int N_SRC = 16,
  parameter int N_PIN_IN = 8,
  parameter int I2C_CLK_IN = 0,
  parameter int I2C_DAT_IN = 1,
  parameter logic [N_PINS-1:0] I2C_PIN_MASK = 8'h0f
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic i_DEV_RST,
  input wire logic i_SLEEP,
  input wire logic i_ONE_SHOT_OPT,
  input wire prsl_wr_s i_WR,
  input wire logic [N_SRC-1:0] i_SRC,
  input wire logic [N_SRC-1:0] i_SRC_OE,
  input wire logic [N_SRC-1:0] i_SRC_OVR,
  input wire logic [N_PINS-1:0] i_DIR_INPUT,
  input wire logic [N_PINS-1:0] i_THRESH_ST,
  input wire logic i_I2C_MODE,
  input wire logic [N_PINS-1:0] i_PIN_IN,
  output prsl_pin_s [N_PINS-1:0] o_PIN,
  output logic [N_PIN_IN-1:0] o_PERIPH_IN,
  output logic o_LOCKED,
  output logic o_SEQ_ARMED,
  output logic o_WR_REFUSED
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [`PRSL_SEL_W-1:0] out_sel_q [N_PINS];
  logic [`PRSL_SEL_W-1:0] out_sel_d [N_PINS];
  logic [`PRSL_SEL_W-1:0] in_sel_q [N_PIN_IN];
  logic [`PRSL_SEL_W-1:0] in_sel_d [N_PIN_IN];
  logic locked_q;
  logic locked_d;
  prsl_seq_e seq_q;
  prsl_seq_e seq_d;
  prsl_os_e os_q;
  prsl_os_e os_d;
  logic refused_q;
  logic refused_d;
  logic [N_PINS-1:0] pin_meta_q;
  logic [N_PINS-1:0] pin_sync_q;
  logic [N_PIN_IN-1:0] periph_q;
  logic [N_PIN_IN-1:0] periph_d;
  logic lock_wr;
  logic lock_ok;
  logic new_lock;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  // Pads are asynchronous; nothing reads the first stage but the second
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= i_PIN_IN;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Key sequence and lock
  // ----------------------------------------------------------------
  // A lock write only counts right after the two keys
  always_comb begin
    seq_d = seq_q;
    locked_d = locked_q;
    os_d = os_q;
    lock_wr = i_WR.en && (i_WR.tgt == PRSL_TGT_LOCK);
    new_lock = i_WR.data[`PRSL_LOCK_BIT];
    // One-shot option caps changes at one clear and one set
    lock_ok = !i_ONE_SHOT_OPT || (os_q != PRSL_OS_SPENT);
    if (i_WR.en) begin
      // Every write moves the sequence; strays drop it
      seq_d = PRSL_SEQ_IDLE;
      if (lock_wr && i_WR.data == `PRSL_KEY_FIRST) begin
        seq_d = PRSL_SEQ_KEY1;
      end else if (lock_wr && seq_q == PRSL_SEQ_KEY1 && i_WR.data == `PRSL_KEY_SECOND) begin
        seq_d = PRSL_SEQ_ARMED;
      end else if (lock_wr && seq_q == PRSL_SEQ_ARMED && lock_ok) begin
        locked_d = new_lock;
        if (i_ONE_SHOT_OPT && new_lock != locked_q) begin
          os_d = new_lock ? PRSL_OS_SPENT : PRSL_OS_CLEARED;
        end
      end
    end
    // Non-power-on reset rearms budget, keeps lock and selections
    if (i_DEV_RST) begin
      seq_d = PRSL_SEQ_IDLE;
      os_d = PRSL_OS_FRESH;
    end
  end

  // Async reset is power-on: the only reset that unlocks
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      locked_q <= `PRSL_LOCK_RST;
      seq_q <= PRSL_SEQ_IDLE;
      os_q <= PRSL_OS_FRESH;
    end else begin
      locked_q <= locked_d;
      seq_q <= seq_d;
      os_q <= os_d;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Shared by both tables; an index past the table matches no slot
  function automatic logic idx_hit(input logic [7:0] idx, input int slot);
    return idx == 8'(slot);
  endfunction : idx_hit

  // ----------------------------------------------------------------
  // Selection registers
  // ----------------------------------------------------------------
  // Writes land only while unlocked; sleep has no path here at all
  always_comb begin
    out_sel_d = out_sel_q;
    in_sel_d = in_sel_q;
    refused_d = 1'b0;
    if (i_WR.en && i_WR.tgt != PRSL_TGT_LOCK) begin
      if (locked_q) begin
        refused_d = 1'b1;
      end else if (i_WR.tgt == PRSL_TGT_OUT) begin
        for (int p = 0; p < N_PINS; p++) begin
          if (idx_hit(i_WR.idx, p)) out_sel_d[p] = i_WR.data;
        end
      end else begin
        for (int k = 0; k < N_PIN_IN; k++) begin
          if (idx_hit(i_WR.idx, k)) in_sel_d[k] = i_WR.data;
        end
      end
    end
  end

  // Only power-on restores defaults
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int p = 0; p < N_PINS; p++) out_sel_q[p] <= `PRSL_OUT_SEL_RST;
      for (int k = 0; k < N_PIN_IN; k++) in_sel_q[k] <= `PRSL_IN_SEL_RST;
      refused_q <= 1'b0;
    end else begin
      out_sel_q <= out_sel_d;
      in_sel_q <= in_sel_d;
      refused_q <= refused_d;
    end
  end

  // ----------------------------------------------------------------
  // Input routing
  // ----------------------------------------------------------------
  // Each peripheral input picks any pin; codes past the pins read low
  always_comb begin
    for (int k = 0; k < N_PIN_IN; k++) begin
      periph_d[k] = prsl_pick(`PRSL_PICK_W'(pin_sync_q), in_sel_q[k]);
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      periph_q <= '0;
    end else begin
      periph_q <= periph_d;
    end
  end

  // ----------------------------------------------------------------
  // Output routing, one slice per pin
  // ----------------------------------------------------------------
  // I2C buffer only when the pin is dedicated and carries I2C input;
  // software is expected to aim both directions at that same pin
  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    logic i2c_here;
    assign i2c_here = i_I2C_MODE && I2C_PIN_MASK[p] &&
      (in_sel_q[I2C_CLK_IN] == 8'(p) || in_sel_q[I2C_DAT_IN] == 8'(p));
    prsl_pin_slice #(
      .N_SRC(N_SRC)
    ) u_slice (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .i_sel(out_sel_q[p]),
      .i_src(i_SRC),
      .i_src_oe(i_SRC_OE),
      .i_src_ovr(i_SRC_OVR),
      .i_dir_input(i_DIR_INPUT[p]),
      .i_thresh_st(i_THRESH_ST[p]),
      .i_i2c_here(i2c_here),
      .o_pin(o_PIN[p])
    );
  end

  // Status outputs
  assign o_PERIPH_IN = periph_q;
  assign o_LOCKED = locked_q;
  assign o_SEQ_ARMED = (seq_q == PRSL_SEQ_ARMED);
  assign o_WR_REFUSED = refused_q;
endmodule : prsl_top

// ===== bench/prsl_top_sva.sv
// Port assertions for the pin routing select and lock block
`timescale 1ns/1ps
module prsl_top_sva import prsl_pkg::*; #(
  parameter int N_PINS = 8,
  parameter int N_SRC = 16
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic i_DEV_RST,
  input wire logic i_ONE_SHOT_OPT,
  input wire prsl_wr_s i_WR,
  input wire logic [N_SRC-1:0] i_SRC_OE,
  input wire logic [N_SRC-1:0] i_SRC_OVR,
  input wire logic [N_PINS-1:0] i_DIR_INPUT,
  input wire logic [N_PINS-1:0] i_THRESH_ST,
  input wire logic i_I2C_MODE,
  input wire prsl_pin_s [N_PINS-1:0] o_PIN,
  input wire logic o_LOCKED,
  input wire logic o_SEQ_ARMED,
  input wire logic o_WR_REFUSED
);
  logic [N_PINS-1:0] oe_v;
  logic [N_PINS-1:0] st_v;
  logic lk_wr;
  logic sel_wr;
  // Flatten pin structs so whole vectors can be compared
  always_comb begin
    for (int p = 0; p < N_PINS; p++) begin
      oe_v[p] = o_PIN[p].oe;
      st_v[p] = (o_PIN[p].buf_kind == PRSL_BUF_SCHMITT);
    end
  end
  assign lk_wr = i_WR.en && (i_WR.tgt == PRSL_TGT_LOCK);
  assign sel_wr = i_WR.en && (i_WR.tgt != PRSL_TGT_LOCK);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  a_lock_keyed: assert property ($changed(o_LOCKED) |-> $past(o_SEQ_ARMED) && $past(lk_wr))
    else $error("lock moved without armed write");
  a_lock_value: assert property (lk_wr && o_SEQ_ARMED && !i_ONE_SHOT_OPT && !i_DEV_RST
    && i_WR.data != 8'h55
    |=> o_LOCKED == $past(i_WR.data[0]))
    else $error("lock write not taken");
  a_keys_arm: assert property ((lk_wr && i_WR.data == 8'h55 && !i_DEV_RST ##1 !i_WR.en
    && !i_DEV_RST ##1 lk_wr && i_WR.data == 8'haa && !i_DEV_RST) |=> o_SEQ_ARMED)
    else $error("keys did not arm");
  a_other_cancels: assert property (sel_wr |=> !o_SEQ_ARMED)
    else $error("sequence kept after other write");
  a_dev_rst_disarm: assert property (i_DEV_RST |=> !o_SEQ_ARMED)
    else $error("sequence kept over reset");
  a_locked_refuse: assert property (sel_wr && o_LOCKED |=> o_WR_REFUSED)
    else $error("locked write not refused");
  a_refuse_cause: assert property (o_WR_REFUSED |-> $past(o_LOCKED) && $past(sel_wr))
    else $error("refusal without locked write");
  a_lock_holds: assert property (!lk_wr |=> $stable(o_LOCKED))
    else $error("lock moved without write");
  a_dir_owns_oe: assert property (i_SRC_OVR == '0 |=> oe_v == ~$past(i_DIR_INPUT))
    else $error("driver not owned by direction");
  a_ovr_sets_oe: assert property (i_SRC_OVR == '1 && (i_SRC_OE == '0 || i_SRC_OE == '1)
    |=> oe_v == {N_PINS{$past(i_SRC_OE[0])}}) else $error("override enable ignored");
  a_thresh_buf: assert property (!i_I2C_MODE |=> st_v == $past(i_THRESH_ST))
    else $error("buffer kind wrong");
endmodule : prsl_top_sva
bind prsl_top prsl_top_sva #(.N_PINS(N_PINS), .N_SRC(N_SRC)) i_sva (.I_CLK(I_CLK),
  .I_ARST_N(I_ARST_N), .i_DEV_RST(i_DEV_RST), .i_ONE_SHOT_OPT(i_ONE_SHOT_OPT), .i_WR(i_WR),
  .i_SRC_OE(i_SRC_OE), .i_SRC_OVR(i_SRC_OVR), .i_DIR_INPUT(i_DIR_INPUT),
  .i_THRESH_ST(i_THRESH_ST), .i_I2C_MODE(i_I2C_MODE), .o_PIN(o_PIN), .o_LOCKED(o_LOCKED),
  .o_SEQ_ARMED(o_SEQ_ARMED), .o_WR_REFUSED(o_WR_REFUSED));

// ===== bench/prsl_pin_model.sv
// Pad wires: our driver when enabled, otherwise the outside world
`timescale 1ns/1ps
module prsl_pin_model import prsl_pkg::*; #(
  parameter int N_PINS = 8
) (
  input wire prsl_pin_s [N_PINS-1:0] i_pin,
  input wire logic [N_PINS-1:0] i_ext,
  output logic [N_PINS-1:0] o_pad
);
  // Outside drive stands in for an undriven pad, no pull assumed
  always_comb begin
    for (int p = 0; p < N_PINS; p++) begin
      o_pad[p] = i_pin[p].oe ? i_pin[p].out : i_ext[p];
    end
  end
endmodule : prsl_pin_model

// ===== bench/pin_output_select_lock_tb.sv
// Self-checking bench for the pin routing select and lock block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module pin_output_select_lock_tb import prsl_pkg::*; ;
  logic clk = 0, arst_n = 0, dev_rst = 0, sleep = 0, opt = 0, i2c = 0;
  prsl_wr_s wr = '0;
  logic [15:0] src = '0, src_oe = '0, src_ovr = '0;
  logic [7:0] dir = '0, thr = '0, ext = '0, pad, p_in, oe_v, out_v, i2c_v, ev, pv;
  prsl_pin_s [7:0] pins;
  logic locked, armed, refused;
  logic [16:0] rnd = 17'h18080;
  logic [3:0] sel [8];
  logic [19:0] q[$];
  int err_count = 0, checks_done = 0;
  event go;
  always #50 clk = ~clk;
  prsl_top i_dut (.I_CLK(clk), .I_ARST_N(arst_n), .i_DEV_RST(dev_rst), .i_SLEEP(sleep),
    .i_ONE_SHOT_OPT(opt), .i_WR(wr), .i_SRC(src), .i_SRC_OE(src_oe), .i_SRC_OVR(src_ovr),
    .i_DIR_INPUT(dir), .i_THRESH_ST(thr), .i_I2C_MODE(i2c), .i_PIN_IN(pad), .o_PIN(pins),
    .o_PERIPH_IN(p_in), .o_LOCKED(locked), .o_SEQ_ARMED(armed), .o_WR_REFUSED(refused));
  prsl_pin_model i_pads (.i_pin(pins), .i_ext(ext), .o_pad(pad));
  // Pin fields gathered into vectors
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      oe_v[p] = pins[p].oe;
      out_v[p] = pins[p].out;
      i2c_v[p] = (pins[p].buf_kind == PRSL_BUF_I2C);
    end
  end
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  // One write: raised after an edge, dropped after the taking edge
  task automatic wr_op(input prsl_tgt_e t, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk) #1 wr = '{1'b1, t, i, d};
    @(posedge clk) #1 wr.en = 1'b0;
  endtask : wr_op
  task automatic lock_seq(input logic [7:0] d);
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'h55);
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'haa);
    wr_op(PRSL_TGT_LOCK, 8'h00, d);
  endtask : lock_seq
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic exp(input logic [3:0] id, input logic [15:0] v);
    q.push_back({id, v});
    ->go;
  endtask : exp
  task automatic finish_test();
    // Let the monitor drain notes made in this same time step
    wait (q.size() == 0);
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // -------------------------------------------------------------
  // Monitor: oldest note against the output it names
  // -------------------------------------------------------------
  always @(go) begin
    logic [19:0] e;
    logic [15:0] o;
    while (q.size() > 0) begin
      e = q.pop_front();
      case (e[19:16])
        4'h0: o = {15'h0000, locked};
        4'h1: o = {15'h0000, armed};
        4'h2: o = {15'h0000, refused};
        4'h3: o = {8'h00, p_in};
        4'h4: o = {8'h00, oe_v};
        4'h5: o = {8'h00, out_v};
        default: o = {8'h00, i2c_v};
      endcase
      `CHK(o, e[15:0])
    end
  end
  // Hang guard, generous against a run of about 125 cycles
  initial begin
    #200_000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 arst_n = 1;
    exp(4'h0, 16'h0000);
    rnd = lfsr(rnd);
    src = rnd[15:0];
    dir = rnd[7:0];
    for (int p = 0; p < 8; p++) begin
      rnd = lfsr(rnd);
      sel[p] = rnd[3:0];
      ev[p] = src[rnd[3:0]];
      wr_op(PRSL_TGT_OUT, p[7:0], {4'h0, rnd[3:0]});
    end
    cyc(2);
    exp(4'h5, {8'h00, ev});
    exp(4'h4, {8'h00, ~dir});
    src_ovr = '1;
    src_oe = '1;
    dir = '1;
    cyc(2);
    exp(4'h4, 16'h00ff);
    src_oe = '0;
    cyc(2);
    exp(4'h4, 16'h0000);
    src_ovr = '0;
    $display("output select done");
    i2c = 1'b1;
    thr = '1;
    wr_op(PRSL_TGT_IN, 8'h00, 8'h02);
    wr_op(PRSL_TGT_IN, 8'h01, 8'h06);
    cyc(2);
    exp(4'h6, 16'h0004);
    i2c = 1'b0;
    dir = 8'hf0;
    rnd = lfsr(rnd);
    ext = rnd[7:0];
    // Inputs read pins in reverse; driven pins loop back their own output
    for (int i = 0; i < 8; i++) begin
      pv[i] = dir[7-i] ? ext[7-i] : ev[7-i];
      wr_op(PRSL_TGT_IN, i[7:0], 8'(7 - i));
    end
    cyc(5);
    exp(4'h3, {8'h00, pv});
    sleep = 1'b1;
    cyc(3);
    exp(4'h3, {8'h00, pv});
    exp(4'h5, {8'h00, ev});
    sleep = 1'b0;
    $display("input select done");
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'h55);
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'haa);
    exp(4'h1, 16'h0001);
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'h01);
    exp(4'h0, 16'h0001);
    wr_op(PRSL_TGT_OUT, 8'h00, {4'h0, ~sel[0]});
    exp(4'h2, 16'h0001);
    wr_op(PRSL_TGT_IN, 8'h00, 8'h03);
    exp(4'h2, 16'h0001);
    cyc(4);
    exp(4'h5, {8'h00, ev});
    exp(4'h3, {8'h00, pv});
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'h55);
    wr_op(PRSL_TGT_OUT, 8'h01, 8'h00);
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'haa);
    wr_op(PRSL_TGT_LOCK, 8'h00, 8'h00);
    exp(4'h0, 16'h0001);
    lock_seq(8'h00);
    exp(4'h0, 16'h0000);
    $display("lock done");
    @(posedge clk) #1 dev_rst = 1'b1;
    @(posedge clk) #1 dev_rst = 1'b0;
    opt = 1'b1;
    lock_seq(8'h01);
    lock_seq(8'h00);
    exp(4'h0, 16'h0001);
    @(posedge clk) #1 dev_rst = 1'b1;
    @(posedge clk) #1 dev_rst = 1'b0;
    exp(4'h0, 16'h0001);
    lock_seq(8'h00);
    exp(4'h0, 16'h0000);
    lock_seq(8'h01);
    lock_seq(8'h00);
    exp(4'h0, 16'h0001);
    $display("one shot done");
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(3);
    exp(4'h0, 16'h0000);
    exp(4'h5, {8'h00, {8{src[0]}}});
    $display("power on reset done");
    finish_test();
  end
endmodule : pin_output_select_lock_tb
